// ---- xod_pkg.sv ----
// constants and types of the operand field decoder
package xod_pkg;

   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] XOD_CTRL_OFF   = 8'h00;
   localparam logic [7:0] XOD_INSTR_OFF  = 8'h04;
   localparam logic [7:0] XOD_BASEV_OFF  = 8'h14;
   localparam logic [7:0] XOD_INDEXV_OFF = 8'h18;
   localparam logic [7:0] XOD_STATUS_OFF = 8'h1C;
   localparam logic [7:0] XOD_EA_OFF     = 8'h20;
   localparam logic [7:0] XOD_IMM_OFF    = 8'h24;
   localparam logic [7:0] XOD_DISP_OFF   = 8'h28;
   localparam logic [7:0] XOD_FIELDS_OFF = 8'h2C;

   localparam int XOD_INSTR_WORDS = 4;

   // ----------------------------------------
   // control word fields and reset values
   // ----------------------------------------
   localparam int XOD_C_DEF_OP32   = 0;
   localparam int XOD_C_DEF_ADDR32 = 1;
   localparam int XOD_C_OP_PFX     = 2;
   localparam int XOD_C_ADDR_PFX   = 3;
   localparam int XOD_C_OPC2       = 4;
   localparam int XOD_C_MODRM      = 5;
   localparam int XOD_C_IMM_LSB    = 6;
   localparam int XOD_C_SIGN       = 8;
   localparam int XOD_C_STRDST     = 9;
   localparam int XOD_C_START      = 10;
   localparam logic [9:0]  XOD_CTRL_RST = 10'h000;
   localparam logic [31:0] XOD_WORD_RST = 32'h0000_0000;

   // ----------------------------------------
   // encodings
   // ----------------------------------------
   typedef enum logic [1:0] {
      XOD_IMM_NONE = 2'h0,
      XOD_IMM_FIX8 = 2'h1,
      XOD_IMM_VAR  = 2'h2
   } xod_imm_t;

   typedef enum logic [1:0] {
      XOD_ST_IDLE = 2'b00,
      XOD_ST_CALC = 2'b01,
      XOD_ST_DONE = 2'b11
   } xod_state_t;

   localparam logic [2:0] XOD_SEG_ES = 3'h0;
   localparam logic [2:0] XOD_SEG_SS = 3'h2;
   localparam logic [2:0] XOD_SEG_DS = 3'h3;
   localparam logic [2:0] XOD_SEG_RSV = 3'h6;

   localparam logic [2:0] XOD_REG_BX  = 3'h3;
   localparam logic [2:0] XOD_REG_SP  = 3'h4;
   localparam logic [2:0] XOD_REG_BP  = 3'h5;
   localparam logic [2:0] XOD_REG_SI  = 3'h6;
   localparam logic [2:0] XOD_REG_DI  = 3'h7;
   localparam logic [2:0] XOD_RM_SIB  = 3'h4;
   localparam logic [2:0] XOD_RM_D16  = 3'h6;
   localparam logic [2:0] XOD_NO_IDX  = 3'h4;

   localparam logic [1:0] XOD_MOD_NODISP = 2'h0;
   localparam logic [1:0] XOD_MOD_D8     = 2'h1;
   localparam logic [1:0] XOD_MOD_DW     = 2'h2;
   localparam logic [1:0] XOD_MOD_REG    = 2'h3;
   localparam logic [1:0] XOD_SS_X1      = 2'h0;

   localparam logic [3:0] XOD_LEN_B1 = 4'h1;
   localparam logic [3:0] XOD_LEN_B2 = 4'h2;
   localparam logic [3:0] XOD_LEN_B4 = 4'h4;

endpackage

// ---- xod_operand_decoder.sv ----
// operand addressing field decoder with AHB-Lite register slave
//
// Function
// - opcode is one or two bytes; w, d, s, cond fields come from it
// - scale-index-base byte only with 32-bit addressing, right after mode byte
// - parse order opcode, mode byte, sib, displacement, immediate last
// - variable immediate is one byte if w=0, else operand size
// - 16-bit forms: pair tables, r/m 110 mod 00 direct, frame pointer uses stack
// - 32-bit no sib: r/m base, mod00 r/m101 absolute, mod01/10 add d8/d32
// - 32-bit with r/m 100 and mod not 11 expects sib byte
// - displacement sits after mode byte or sib byte and before immediate
// - scale code 00..11 multiplies index by 1, 2, 4, 8
// - index code 100 means no index; nonzero scale then undefined
// - base 101 with mod 00 drops frame pointer, uses 32-bit displacement
// - sib address base+scaled index+disp; sp/fp bases use stack segment
// - w=0 byte operand, w=1 16 or 32 bits by operation size
// - short segment code 00..11 ES CS SS DS; long adds two, 110/111 reserved
// - register code picks full registers; w=0 low then high byte registers
// - mod 11 makes r/m a register selector
// - frame pointer operands use the stack segment
// - string destinations via destination index always use extra segment
// - d=0 reg is source, r/m destination; d=1 swapped
// - sign-extend bit only affects 8-bit immediate into full operand
// - field widths 1 for w/d/s, 3 reg/rm/index/base, 2 mod/ss, 4 cond
// - s=1 sign-extends 8-bit immediate, s=0 leaves it unchanged
// - size prefixes invert default size for one instruction only
// - condition field upper three bits choose test, low bit negates
`timescale 1ns/100ps
`default_nettype none

module xod_operand_decoder
   import xod_pkg::*;
(
   // clock and reset
   input  wire  logic        sys_clk,
   input  wire  logic        sys_rst,
   // AHB-Lite slave
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic        hready,
   input  wire  logic [31:0] hwdata,
   output logic        [31:0] hrdata,
   output logic              hreadyout,
   output logic              hresp,
   // fetch stage
   output logic              decDone,
   output logic        [3:0] insnLength
);

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic        wrActQ;
   logic        rdActQ;
   logic [7:0]  addrQ;
   wire         takeReq = hsel & hready & htrans[1];

   // hsize is not checked: only whole-word transfers are used
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wrActQ <= 1'b0;
         rdActQ <= 1'b0;
         addrQ  <= 8'h00;
      end else if (hready) begin
         wrActQ <= takeReq & hwrite;
         rdActQ <= takeReq & ~hwrite;
         addrQ  <= {haddr[7:2], 2'b00};
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   wire wrCtrl   = wrActQ & (addrQ == XOD_CTRL_OFF);
   wire wrBaseV  = wrActQ & (addrQ == XOD_BASEV_OFF);
   wire wrIndexV = wrActQ & (addrQ == XOD_INDEXV_OFF);
   wire startReq = wrCtrl & hwdata[XOD_C_START];
   // ----------------------------------------
   // software registers
   // ----------------------------------------
   logic [9:0]  ctrlQ;
   logic [31:0] baseValQ;
   logic [31:0] indexValQ;
   logic [31:0] instrQ [XOD_INSTR_WORDS];
   xod_state_t  stateQ;
   wire         calcNow = (stateQ == XOD_ST_CALC);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrlQ <= XOD_CTRL_RST;
      end else if (wrCtrl) begin
         ctrlQ <= hwdata[9:0];
      end else if (calcNow) begin
         ctrlQ[XOD_C_OP_PFX]   <= 1'b0;
         ctrlQ[XOD_C_ADDR_PFX] <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         baseValQ  <= XOD_WORD_RST;
         indexValQ <= XOD_WORD_RST;
      end else begin
         if (wrBaseV) baseValQ <= hwdata;
         if (wrIndexV) indexValQ <= hwdata;
      end
   end
   // instruction bytes, little-endian within each word
   logic [7:0] ib [4*XOD_INSTR_WORDS];
   genvar gw;
   generate
      for (gw = 0; gw < XOD_INSTR_WORDS; gw++) begin : g_instr
         wire wrThis = wrActQ & (addrQ == XOD_INSTR_OFF + 8'(4*gw));
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               instrQ[gw] <= XOD_WORD_RST;
            end else if (wrThis) begin
               instrQ[gw] <= hwdata;
            end
         end
         assign ib[4*gw]   = instrQ[gw][7:0];
         assign ib[4*gw+1] = instrQ[gw][15:8];
         assign ib[4*gw+2] = instrQ[gw][23:16];
         assign ib[4*gw+3] = instrQ[gw][31:24];
      end
   endgenerate
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // little-endian field, optionally sign-extended from its top byte
   function automatic logic [31:0] assemble(
      input logic [7:0] b0,
      input logic [7:0] b1,
      input logic [7:0] b2,
      input logic [7:0] b3,
      input logic [3:0] len,
      input logic       sx
   );
      logic [31:0] v;
      v = 32'h0000_0000;
      case (len)
         XOD_LEN_B1: v = {{24{sx & b0[7]}}, b0};
         XOD_LEN_B2: v = {{16{sx & b1[7]}}, b1, b0};
         XOD_LEN_B4: v = {b3, b2, b1, b0};
         default:    v = 32'h0000_0000;
      endcase
      return v;
   endfunction
   // stack segment for frame or stack pointer bases, data otherwise
   function automatic logic [2:0] baseSeg(
      input logic       used,
      input logic [2:0] code
   );
      logic sp;
      sp = used & ((code == XOD_REG_BP) | (code == XOD_REG_SP));
      return sp ? XOD_SEG_SS : XOD_SEG_DS;
   endfunction
   // ----------------------------------------
   // opcode and sizes
   // ----------------------------------------
   wire       opc2     = ctrlQ[XOD_C_OPC2];
   wire       hasModrm = ctrlQ[XOD_C_MODRM];
   wire [1:0] immKind  = ctrlQ[XOD_C_IMM_LSB +: 2];
   wire       useSign  = ctrlQ[XOD_C_SIGN];
   wire       strDest  = ctrlQ[XOD_C_STRDST];
   wire [3:0] opLen    = opc2 ? XOD_LEN_B2 : XOD_LEN_B1;
   wire [7:0] lastOpc  = opc2 ? ib[1] : ib[0];
   wire       wBit     = lastOpc[0];
   wire       dBit     = lastOpc[1];
   wire       sBit     = lastOpc[1];
   wire [3:0] condFld  = lastOpc[3:0];
   wire [2:0] condSel  = condFld[3:1];
   wire       condNeg  = condFld[0];
   wire op32   = ctrlQ[XOD_C_DEF_OP32] ^ ctrlQ[XOD_C_OP_PFX];
   wire addr32 = ctrlQ[XOD_C_DEF_ADDR32] ^ ctrlQ[XOD_C_ADDR_PFX];
   // operand bytes: 1, 2 or 4
   wire [3:0] opBytes = ~wBit ? XOD_LEN_B1 :
                        (op32 ? XOD_LEN_B4 : XOD_LEN_B2);
   // ----------------------------------------
   // mode byte and sib
   // ----------------------------------------
   wire [7:0] modrm   = ib[opLen];
   wire [1:0] modF    = modrm[7:6];
   wire [2:0] regF    = modrm[5:3];
   wire [2:0] rmF     = modrm[2:0];
   wire       regMode = hasModrm & (modF == XOD_MOD_REG);
   wire       memMode = hasModrm & ~regMode;
   wire       sibHere = memMode & addr32 & (rmF == XOD_RM_SIB);
   wire [3:0] sibPos  = opLen + 4'h1;
   wire [7:0] sib     = ib[sibPos];
   wire [1:0] ssF     = sib[7:6];
   wire [2:0] idxF    = sib[5:3];
   wire [2:0] baseF   = sib[2:0];
   // ----------------------------------------
   // displacement length
   // ----------------------------------------
   wire noBase32 = (modF == XOD_MOD_NODISP) &
                   (sibHere ? (baseF == XOD_REG_BP)
                            : (rmF == XOD_REG_BP));
   wire direct16 = (modF == XOD_MOD_NODISP) &
                   (rmF == XOD_RM_D16);
   logic [3:0] dispLen;
   always_comb begin
      dispLen = 4'h0;
      if (memMode) begin
         case (modF)
            XOD_MOD_NODISP: begin
               if (addr32) begin
                  dispLen = noBase32 ? XOD_LEN_B4 : 4'h0;
               end else begin
                  dispLen = direct16 ? XOD_LEN_B2 : 4'h0;
               end
            end
            XOD_MOD_D8: dispLen = XOD_LEN_B1;
            XOD_MOD_DW: begin
               dispLen = addr32 ? XOD_LEN_B4 : XOD_LEN_B2;
            end
            default: dispLen = 4'h0;
         endcase
      end
   end
   // ----------------------------------------
   // field positions in parse order
   // ----------------------------------------
   wire [3:0] modLen  = {3'b000, hasModrm};
   wire [3:0] sibLen  = {3'b000, sibHere};
   wire [3:0] dispOff = opLen + modLen + sibLen;
   wire [3:0] immOff  = dispOff + dispLen;
   logic [3:0] immLen;
   always_comb begin
      case (immKind)
         XOD_IMM_FIX8: immLen = XOD_LEN_B1;
         XOD_IMM_VAR:  immLen = opBytes;
         default:      immLen = 4'h0;
      endcase
   end
   wire [3:0] totalLen = immOff + immLen;
   // ----------------------------------------
   // displacement and immediate values
   // ----------------------------------------
   wire [31:0] dispVal = assemble(ib[dispOff],
                                  ib[dispOff + 4'h1],
                                  ib[dispOff + 4'h2],
                                  ib[dispOff + 4'h3],
                                  dispLen, 1'b1);
   // only a one-byte immediate into a full operand can widen
   wire immWiden = useSign & sBit & wBit &
                   (immLen == XOD_LEN_B1);
   wire [31:0] immRaw = assemble(ib[immOff],
                                 ib[immOff + 4'h1],
                                 ib[immOff + 4'h2],
                                 ib[immOff + 4'h3],
                                 immLen, immWiden);
   wire [31:0] immVal = op32 ? immRaw
                             : {16'h0000, immRaw[15:0]};
   // ----------------------------------------
   // address components
   // ----------------------------------------
   logic       useBase;
   logic       useIndex;
   logic [2:0] baseCode;
   logic [2:0] indexCode;
   logic [1:0] scaleCode;

   always_comb begin
      useBase   = 1'b0;
      useIndex  = 1'b0;
      baseCode  = XOD_REG_BX;
      indexCode = XOD_REG_SI;
      scaleCode = XOD_SS_X1;
      if (memMode & ~addr32) begin
         // pairs for 000..011, single SI/DI/BP/BX for 100..111
         useBase   = ~rmF[2] | rmF[1];
         useIndex  = ~rmF[2] | ~rmF[1];
         baseCode  = rmF[2] ? (rmF[0] ? XOD_REG_BX : XOD_REG_BP)
                            : (rmF[1] ? XOD_REG_BP : XOD_REG_BX);
         indexCode = rmF[0] ? XOD_REG_DI : XOD_REG_SI;
         if (direct16) useBase = 1'b0;
      end else if (memMode & ~sibHere) begin
         useBase  = ~noBase32;
         baseCode = rmF;
      end else if (memMode) begin
         useBase   = ~noBase32;
         baseCode  = baseF;
         useIndex  = (idxF != XOD_NO_IDX);
         indexCode = idxF;
         scaleCode = ssF;
      end
   end
   wire undefEa = sibHere & (idxF == XOD_NO_IDX) &
                  (ssF != XOD_SS_X1);
   wire [31:0] basePart  = useBase ? baseValQ : 32'h0000_0000;
   wire [31:0] indexPart = useIndex ? (indexValQ << scaleCode)
                                    : 32'h0000_0000;
   wire [31:0] eaSum     = basePart + indexPart + dispVal;
   // 16-bit forms wrap inside the segment
   wire [31:0] eaVal     = addr32 ? eaSum
                                  : {16'h0000, eaSum[15:0]};
   // string destination segment cannot be overridden
   wire [2:0] eaSeg = strDest ? XOD_SEG_ES
                              : baseSeg(useBase, baseCode);
   // ----------------------------------------
   // register and segment selections
   // ----------------------------------------
   wire [1:0] segShort = lastOpc[4:3];
   wire [2:0] segLong  = regF;
   wire       segRsvd  = (segLong >= XOD_SEG_RSV);
   // byte registers: code[2] picks the high half of A, C, D, B
   wire       regHigh  = ~wBit & regF[2];
   wire       rmHigh   = regMode & ~wBit & rmF[2];
   wire       regIsSrc = ~dBit;
   // reserved long segment flag is reported in status, not here
   wire [31:0] fieldsVal = {
      condNeg, condSel, segLong, segShort,
      eaSeg, rmHigh, regHigh, regIsSrc, opBytes[2:0],
      scaleCode, indexCode, baseCode, rmF, regF
   };
   // ----------------------------------------
   // decode sequence
   // ----------------------------------------
   logic [31:0] eaQ;
   logic [31:0] immQ;
   logic [31:0] dispQ;
   logic [31:0] fieldsQ;
   logic [3:0]  lenQ;
   logic [3:0]  dispLenQ;
   logic [3:0]  immLenQ;
   logic [5:0]  flagsQ;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stateQ <= XOD_ST_IDLE;
      end else begin
         case (stateQ)
            XOD_ST_IDLE: if (startReq) stateQ <= XOD_ST_CALC;
            XOD_ST_CALC: stateQ <= XOD_ST_DONE;
            XOD_ST_DONE: if (startReq) stateQ <= XOD_ST_CALC;
            default:     stateQ <= XOD_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         eaQ      <= XOD_WORD_RST;
         immQ     <= XOD_WORD_RST;
         dispQ    <= XOD_WORD_RST;
         fieldsQ  <= XOD_WORD_RST;
         lenQ     <= 4'h0;
         dispLenQ <= 4'h0;
         immLenQ  <= 4'h0;
         flagsQ   <= 6'h00;
      end else if (calcNow) begin
         eaQ      <= memMode ? eaVal : 32'h0000_0000;
         immQ     <= immVal;
         dispQ    <= dispVal;
         fieldsQ  <= fieldsVal;
         lenQ     <= totalLen;
         dispLenQ <= dispLen;
         immLenQ  <= immLen;
         flagsQ   <= {segRsvd, addr32, op32, undefEa, sibHere, regMode};
      end
   end
   wire doneNow = (stateQ == XOD_ST_DONE);
   wire busyNow = calcNow;
   assign decDone    = doneNow;
   assign insnLength = lenQ;
   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire [31:0] statusVal = {10'h000, flagsQ, immLenQ, dispLenQ,
                            lenQ, 2'b00, busyNow, doneNow};
   wire        rdInstr   = (addrQ >= XOD_INSTR_OFF) &
                           (addrQ < XOD_BASEV_OFF);
   wire [1:0]  rdWord    = 2'(addrQ[3:2] - XOD_INSTR_OFF[3:2]);
   always_comb begin
      hrdata = 32'h0000_0000;
      if (!rdActQ) hrdata = 32'h0000_0000;
      else if (addrQ == XOD_CTRL_OFF) hrdata = {22'h0, ctrlQ};
      else if (rdInstr) hrdata = instrQ[rdWord];
      else if (addrQ == XOD_BASEV_OFF) hrdata = baseValQ;
      else if (addrQ == XOD_INDEXV_OFF) hrdata = indexValQ;
      else if (addrQ == XOD_STATUS_OFF) hrdata = statusVal;
      else if (addrQ == XOD_EA_OFF) hrdata = eaQ;
      else if (addrQ == XOD_IMM_OFF) hrdata = immQ;
      else if (addrQ == XOD_DISP_OFF) hrdata = dispQ;
      else if (addrQ == XOD_FIELDS_OFF) hrdata = fieldsQ;
   end

endmodule // xod_operand_decoder

`default_nettype wire

// ---- xod_fetch_model.sv ----
// fetch stage model that advances by each reported length
`timescale 1ns/100ps
`default_nettype none
module xod_fetch_model (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // decoder side
   input  wire logic        decDone,
   input  wire logic [3:0]  insnLength,
   // fetch pointer
   output var  logic [15:0] fetchPtr_q
);
   logic done_q;
   // ------------------------------
   // advance once per finished decode
   // ------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         done_q     <= 1'b0;
         fetchPtr_q <= 16'h0000;
      end else begin
         done_q <= decDone;
         if (decDone && !done_q) begin
            fetchPtr_q <= fetchPtr_q + {12'h000, insnLength};
         end
      end
   end
endmodule // xod_fetch_model
`default_nettype wire

// ---- xod_monitor.sv ----
// port checker for the operand field decoder
`timescale 1ns/100ps
`default_nettype none
module xod_monitor (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   // register bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // fetch side
   input wire logic        decDone,
   input wire logic [3:0]  insnLength
);
   logic rdPh_q, unmap_q, ctlWr_q, start_q;
   wire  takeReq = hsel & hready & htrans[1];
   // ------------------------------
   // phase tracking
   // ------------------------------
   always_ff @(posedge sys_clk) begin
      rdPh_q  <= takeReq & ~hwrite;
      unmap_q <= haddr[7:2] > 6'd11;
      ctlWr_q <= takeReq & hwrite & (haddr[7:2] == 6'd0);
      start_q <= ctlWr_q & hwdata[10];
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_ready; hreadyout && !hresp; endproperty
   a_ready: assert property (p_ready) else $error("bus not ready or not okay");
   property p_rdzero; !rdPh_q || unmap_q |-> hrdata == 32'h0; endproperty
   a_rdzero: assert property (p_rdzero) else $error("read data not zero");
   property p_start; start_q |-> !decDone ##1 decDone; endproperty
   a_start: assert property (p_start) else $error("decode timing off");
   property p_fall; $fell(decDone) |-> start_q; endproperty
   a_fall: assert property (p_fall) else $error("done fell without start");
   property p_hold; decDone && $past(decDone) |-> $stable(insnLength); endproperty
   a_hold: assert property (p_hold) else $error("length moved while done");
   property p_lenchg; $changed(insnLength) |-> $rose(decDone); endproperty
   a_lenchg: assert property (p_lenchg) else $error("length changed early");
   property p_range; decDone |-> insnLength inside {[4'h1:4'hC]}; endproperty
   a_range: assert property (p_range) else $error("length out of range");
   property p_rst; $fell(sys_rst) |-> !decDone && insnLength == 4'h0; endproperty
   a_rst: assert property (p_rst) else $error("outputs not reset");
   c_done: cover property ($rose(decDone));
   c_unmap: cover property (rdPh_q && unmap_q);
   c_again: cover property (decDone ##1 start_q);
endmodule // xod_monitor
bind xod_operand_decoder xod_monitor u_mon (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .decDone(decDone),
   .insnLength(insnLength));
`default_nettype wire

// ---- x86_operand_field_decoder_tb.sv ----
// self-checking bench for the operand field decoder
`timescale 1ns/100ps
`default_nettype none
module x86_operand_field_decoder_tb;
   import xod_pkg::*;
   logic sys_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, baseV, idxV;
   logic [31:0] eSt, eEa, eDisp, eImm, eFld, eFm;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [7:0]  ib [16];
   logic [3:0]  eLen;
   logic [15:0] eSum = 16'h0000;
   logic        eaOk;
   wire logic [31:0] hrdata;
   wire logic        hreadyout, hresp, decDone;
   wire logic [3:0]  insnLength;
   wire logic [15:0] fetchPtr;
   int n_errors = 0, n_checks = 0, cyc = 0;
   integer seed = 32'hea16db72;
   always #12.5 sys_clk = ~sys_clk;
   xod_operand_decoder u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .decDone(decDone),
      .insnLength(insnLength));
   xod_fetch_model u_fetch (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .decDone(decDone), .insnLength(insnLength), .fetchPtr_q(fetchPtr));
   // ------------------------------
   // bus, compare and closing tasks
   // ------------------------------
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      n_checks++;
      if (seen !== ex) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task end_sim;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'b10;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00; hwdata <= wd;
      // data is taken while it stands, not racing the closing edge
      do begin
         @(negedge sys_clk);
         rd = hrdata;
         @(posedge sys_clk);
      end while (hreadyout !== 1'b1);
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         end_sim;
      end
   end
   // ------------------------------
   // expected decode of the loaded bytes
   // ------------------------------
   function automatic void exp_calc(input logic [9:0] c);
      int p, dl, il, k;
      logic op32, a32, w, s, sib, stk;
      logic [7:0] op, mr;
      logic [1:0] md, ss;
      logic [2:0] rm, ix, bs;
      op32 = c[0] ^ c[2];
      a32 = c[1] ^ c[3];
      p = 1 + c[4];
      op = ib[p-1];
      mr = ib[p];
      w = ib[p-1][0];
      s = ib[p-1][1];
      md = ib[p][7:6]; rm = ib[p][2:0];
      ss = ib[p+1][7:6]; ix = ib[p+1][5:3]; bs = ib[p+1][2:0];
      sib = c[5] && a32 && md != 2'h3 && rm == 3'h4;
      dl = 0;
      if (c[5] && md == 2'h1) dl = 1;
      else if (c[5] && md == 2'h2) dl = a32 ? 4 : 2;
      else if (c[5] && md == 2'h0) dl = a32 ? ((rm == 3'h5 && !sib)
         || (sib && bs == 3'h5) ? 4 : 0) : (rm == 3'h6 ? 2 : 0);
      p = p + c[5] + sib;
      eDisp = 32'h0;
      for (k = dl - 1; k >= 0; k--) eDisp = {eDisp[23:0], ib[p+k]};
      if (dl == 1) eDisp = {{24{eDisp[7]}}, eDisp[7:0]};
      if (dl == 2) eDisp = {{16{eDisp[15]}}, eDisp[15:0]};
      il = c[7:6] == 2'h1 ? 1 : c[7:6] == 2'h2 ? (w ? (op32 ? 4 : 2) : 1) : 0;
      eImm = 32'h0;
      for (k = il - 1; k >= 0; k--) eImm = {eImm[23:0], ib[p+dl+k]};
      if (il == 1 && c[8] && s && w) eImm = {{24{eImm[7]}}, eImm[7:0]};
      if (!op32) eImm = eImm & 32'hFFFF;
      eLen = 4'(p + dl + il);
      eSt = {10'h0, mr[5:3] >= 3'h6, a32, op32,
         sib && ix == 3'h4 && ss != 2'h0, sib, c[5] && md == 2'h3,
         4'(il), 4'(dl), eLen, 4'h1};
      if (md == 2'h3) eEa = 32'h0;
      else if (sib) eEa = ((bs == 3'h5 && md == 2'h0) ? 32'h0 : baseV)
         + (ix == 3'h4 ? 32'h0 : idxV << ss) + eDisp;
      else if (a32) eEa = (rm == 3'h5 && md == 2'h0 ? 32'h0 : baseV) + eDisp;
      else eEa = ((rm < 3'h4 || rm == 3'h7 || (rm == 3'h6 && md != 2'h0)
         ? baseV : 32'h0) + (rm < 3'h6 ? idxV : 32'h0) + eDisp) & 32'hFFFF;
      eaOk = c[5] && !eSt[18];
      stk = sib ? bs == 3'h4 || (bs == 3'h5 && md != 2'h0)
         : a32 ? rm == 3'h5 && md != 2'h0
         : rm == 3'h2 || rm == 3'h3 || (rm == 3'h6 && md != 2'h0);
      stk = stk && c[5] && md != 2'h3;
      eFld = {op[0], op[3:1], mr[5:3], op[4:3],
         (c[9] ? 3'h0 : (stk ? 3'h2 : 3'h3)),
         c[5] && md == 2'h3 && !op[0] && rm[2], !op[0] && mr[5], !op[1],
         (op[0] ? (op32 ? 3'h4 : 3'h2) : 3'h1), ss, ix, bs, rm, mr[5:3]};
      eFm = sib ? 32'hFFFF_FFFF : 32'hFFFF_C03F;
   endfunction
   task decode(input logic [9:0] c);
      int k;
      for (k = 0; k < 4; k++) xfer(1'b1, XOD_INSTR_OFF + 8'(4 * k),
         {ib[4*k+3], ib[4*k+2], ib[4*k+1], ib[4*k]});
      xfer(1'b1, XOD_BASEV_OFF, baseV);
      xfer(1'b1, XOD_INDEXV_OFF, idxV);
      exp_calc(c);
      xfer(1'b1, XOD_CTRL_OFF, {21'h0, 1'b1, c});
      rd = 32'h0;
      for (k = 0; k < 20 && rd[0] !== 1'b1; k++) xfer(1'b0, XOD_STATUS_OFF, 32'h0);
      chk("status", rd, eSt);
      chk("length", {28'h0, insnLength}, {28'h0, eLen});
      xfer(1'b0, XOD_DISP_OFF, 32'h0);
      chk("disp", rd, eDisp);
      xfer(1'b0, XOD_IMM_OFF, 32'h0);
      chk("imm", rd, eImm);
      xfer(1'b0, XOD_FIELDS_OFF, 32'h0);
      chk("fields", rd & eFm, eFld & eFm);
      if (eaOk) begin
         xfer(1'b0, XOD_EA_OFF, 32'h0);
         chk("ea", rd, eEa);
      end
      xfer(1'b0, XOD_CTRL_OFF, 32'h0);
      chk("ctrl", rd, {22'h0, c & 10'h3F3});
      eSum = eSum + {12'h000, eLen};
   endtask
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      int i, k;
      logic [9:0]  c;
      logic [41:0] tbl [5];
      tbl = '{{10'h162, 32'h80E50483}, {10'h0A0, 32'h12340681},
         {10'h031, 32'h00C8890F}, {10'h0AF, 32'h55F04281},
         {10'h022, 32'h018C848B}};
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      xfer(1'b0, XOD_CTRL_OFF, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      xfer(1'b0, XOD_STATUS_OFF, 32'h0);
      chk("status reset", rd, 32'h0);
      xfer(1'b0, 8'hFC, 32'h0);
      chk("unmapped", rd, 32'h0);
      for (i = 0; i < 205; i++) begin
         for (k = 0; k < 16; k++) ib[k] = 8'($random(seed));
         baseV = $random(seed);
         idxV = $random(seed);
         c = 10'($random(seed));
         if (i < 5) begin
            c = tbl[i][41:32];
            {ib[3], ib[2], ib[1], ib[0]} = tbl[i][31:0];
         end
         decode(c);
      end
      repeat (2) @(posedge sys_clk);
      chk("fetch", {16'h0, fetchPtr}, {16'h0, eSum});
      end_sim;
   end
endmodule // x86_operand_field_decoder_tb
`default_nettype wire
